// ---- rtl/cadec_pkg.sv ----
package cadec_pkg;

  // host command op codes
  localparam logic [2:0] CMD_ATTR_RD   = 3'h0;
  localparam logic [2:0] CMD_ATTR_WR   = 3'h1;
  localparam logic [2:0] CMD_MEM_RD    = 3'h2;
  localparam logic [2:0] CMD_MEM_WR    = 3'h3;
  localparam logic [2:0] CMD_STANDBY   = 3'h4;

  // byte lane select for common memory
  localparam logic [1:0] LANE_EVEN     = 2'h1;
  localparam logic [1:0] LANE_ODD      = 2'h2;
  localparam logic [1:0] LANE_WORD     = 2'h3;

  // controller register offsets (software port)
  localparam logic [3:0] OFS_CMD       = 4'h0;
  localparam logic [3:0] OFS_ADDR      = 4'h1;
  localparam logic [3:0] OFS_WDATA     = 4'h2;
  localparam logic [3:0] OFS_RDATA     = 4'h3;
  localparam logic [3:0] OFS_STATUS    = 4'h4;

  // command register fields
  localparam int CMD_OP_LSB            = 0;
  localparam int CMD_LANE_LSB          = 4;
  localparam int CMD_GO_BIT            = 8;

  // status register fields
  localparam int STS_BUSY_BIT          = 0;
  localparam int STS_DONE_BIT          = 1;
  localparam int STS_REFUSED_BIT       = 2;

  // card configuration register space
  localparam logic [10:0] CFG_BASE     = 11'h200;
  localparam logic [10:0] CIS_LAST     = 11'h198;
  localparam logic [1:0] CFG_OPTION    = 2'h0;
  localparam logic [1:0] CFG_STATUS    = 2'h1;
  localparam logic [1:0] CFG_PINREP    = 2'h2;
  localparam logic [1:0] CFG_SOCKET    = 2'h3;

  // pin timing: strobe width and gaps
  localparam int CLK_PERIOD_NS         = 10;
  localparam int SETUP_NS              = 100;
  localparam int STROBE_NS             = 300;
  localparam int HOLD_NS               = 30;
  localparam int SETUP_CYC             = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC            = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC              = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SETUP_CNT     = 6'(SETUP_CYC);
  localparam logic [5:0] STROBE_CNT    = 6'(STROBE_CYC);
  localparam logic [5:0] HOLD_CNT      = 6'(HOLD_CYC);

  // card pin bundle driven by the host
  typedef struct packed {
    logic        ce1_n;
    logic        ce2_n;
    logic        reg_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
  } cadec_pins_t;

  localparam cadec_pins_t PINS_IDLE = '{ce1_n: 1'b1, ce2_n: 1'b1, reg_n: 1'b1,
                                        oe_n: 1'b1, we_n: 1'b1, addr: 11'h000};

  // decoded software command
  typedef struct packed {
    logic [2:0]  op;
    logic [1:0]  lane;
  } cadec_cmd_t;

endpackage

// ---- rtl/cadec_sync.sv ----
`timescale 1ns/100ps
module cadec_sync #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  // asynchronous input and its filtered copy
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          s1_r[i]  <= 1'b0;
          s2_r[i]  <= 1'b0;
          s3_r[i]  <= 1'b0;
          out_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= d_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // change accepted only once stages two and three agree
          if (s2_r[i] == s3_r[i]) begin
            out_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate

  assign d_out = out_r;

endmodule

// ---- rtl/cadec_host.sv ----
`timescale 1ns/100ps
// Function
// RULE_01: attribute accesses are byte wide at even address with CE1 only.
// RULE_02: attribute read holds REG, OE low, WE high; write REG, WE low.
// RULE_03: attribute read data is taken only from the even lane D7-D0.
// RULE_04: config registers sit at A10 low, A9 high, A2:A1 select.
// RULE_05: host locates config registers by reading CIS 0000H to 0198H.
// RULE_06: attribute writes are allowed only at configuration register addresses.
// RULE_07: between cycles the host negates CE or both OE and WE.
// RULE_08: common memory uses CE1 even, CE2 odd, both for word at A0 zero.
// RULE_09: both chip enables high puts the card in standby with lanes floating.
// RULE_10: invalid cycles change nothing and their read data is discarded.
module cadec_host
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // software register port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  // card control pins
  output cadec_pkg::cadec_pins_t card_pins,
  // card data bus, split two-way pins
  input  wire logic [15:0] card_d_in,
  output logic      [15:0] card_d_out,
  output logic      [1:0]  card_d_oe_n
);
  import cadec_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_PULSE = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_GAP   = 5'b10000
  } cadec_state_t;

  cadec_state_t state_r;
  cadec_state_t state_nxt;

  cadec_cmd_t   cmd_r;
  logic [10:0]  addr_r;
  logic [15:0]  wdata_r;
  logic [15:0]  rdata_r;
  logic [15:0]  sw_rdata_r;
  logic         done_r;
  logic         refused_r;
  logic [5:0]   cnt_r;
  cadec_pins_t  pins_r;
  cadec_pins_t  pins_nxt;
  logic [15:0]  dout_r;
  logic [1:0]   doe_n_r;
  logic [1:0]   doe_n_nxt;
  logic [15:0]  d_sync;

  cadec_sync #(.W(16)) u_sync (
    .mclk  (mclk),
    .rstn  (rstn),
    .d_in  (card_d_in),
    .d_out (d_sync)
  );

  // a pending command is legal only if its pin pattern is a valid cycle
  function automatic logic cmd_legal(input cadec_cmd_t c, input logic [10:0] a);
    logic attr;
    logic cfg_hit;
    attr    = (c.op == CMD_ATTR_RD) || (c.op == CMD_ATTR_WR);
    cfg_hit = (a[10:3] == CFG_BASE[10:3]);
    cmd_legal = 1'b1;                                       // even reads open: see RULE_05
    if (attr && (a[0] || c.lane != LANE_EVEN)) begin
      cmd_legal = 1'b0;                                     // see RULE_01
    end
    if (c.op == CMD_ATTR_WR && !cfg_hit) begin
      cmd_legal = 1'b0;                                     // see RULE_06
    end
    if ((c.op == CMD_MEM_RD || c.op == CMD_MEM_WR) &&
        (c.lane == 2'h0 || (c.lane == LANE_WORD && a[0]))) begin
      cmd_legal = 1'b0;                                     // see RULE_08
    end
    if (c.op > CMD_STANDBY) begin
      cmd_legal = 1'b0;
    end
  endfunction

  wire        busy      = (state_r != ST_IDLE);
  wire        sel_cmd   = (sw_addr == OFS_CMD);
  wire        go        = sw_wr && sel_cmd && sw_wdata[CMD_GO_BIT] && !busy;
  wire cadec_cmd_t new_cmd = '{op: sw_wdata[CMD_OP_LSB +: 3], lane: sw_wdata[CMD_LANE_LSB +: 2]};
  wire        new_ok    = cmd_legal(new_cmd, addr_r);
  wire        start     = go && new_ok && (new_cmd.op != CMD_STANDBY);
  wire        is_write  = (cmd_r.op == CMD_ATTR_WR) || (cmd_r.op == CMD_MEM_WR);
  wire        is_attr   = (cmd_r.op == CMD_ATTR_RD) || (cmd_r.op == CMD_ATTR_WR);
  wire        cnt_done  = (cnt_r == 6'h00);

  // address, chip enables and REG for the cycle in flight
  cadec_pins_t pins_addr;
  assign pins_addr.ce1_n = is_attr ? 1'b0 : !cmd_r.lane[0];       // see RULE_08
  assign pins_addr.ce2_n = is_attr ? 1'b1 : !cmd_r.lane[1];       // see RULE_01
  assign pins_addr.reg_n = !is_attr;                              // see RULE_04
  assign pins_addr.oe_n  = 1'b1;
  assign pins_addr.we_n  = 1'b1;
  assign pins_addr.addr  = addr_r;

  always_comb begin
    state_nxt = state_r;
    pins_nxt  = pins_r;
    doe_n_nxt = 2'h3;
    case (state_r)
      ST_IDLE: begin
        pins_nxt = PINS_IDLE;                                     // see RULE_09
        if (start) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        pins_nxt  = pins_addr;
        doe_n_nxt = is_write ? ~cmd_r.lane : 2'h3;
        if (cnt_done) begin
          state_nxt      = ST_PULSE;
          pins_nxt.oe_n  = is_write;                              // see RULE_02
          pins_nxt.we_n  = !is_write;                             // see RULE_02
        end
      end
      ST_PULSE: begin
        doe_n_nxt = is_write ? ~cmd_r.lane : 2'h3;
        if (cnt_done) begin
          state_nxt     = ST_HOLD;
          pins_nxt.oe_n = 1'b1;                                   // see RULE_07
          pins_nxt.we_n = 1'b1;
        end
      end
      ST_HOLD: begin
        doe_n_nxt = is_write ? ~cmd_r.lane : 2'h3;
        if (cnt_done) begin
          state_nxt = ST_GAP;
          pins_nxt  = PINS_IDLE;                                  // see RULE_07
          doe_n_nxt = 2'h3;
        end
      end
      ST_GAP: begin
        if (cnt_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        pins_nxt  = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      pins_r  <= PINS_IDLE;
      doe_n_r <= 2'h3;
    end else begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
      doe_n_r <= doe_n_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 6'h00;
    end else if (state_r != state_nxt) begin
      cnt_r <= (state_nxt == ST_PULSE) ? STROBE_CNT :
               (state_nxt == ST_HOLD)  ? HOLD_CNT : SETUP_CNT;
    end else if (!cnt_done) begin
      cnt_r <= cnt_r - 6'h01;
    end
  end

  // software side registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmd_r   <= '0;
      addr_r  <= 11'h000;
      wdata_r <= 16'h0000;
    end else if (sw_wr && !busy) begin
      if (sel_cmd) begin
        cmd_r <= new_cmd;
      end
      if (sw_addr == OFS_ADDR) begin
        addr_r <= sw_wdata[10:0];
      end
      if (sw_addr == OFS_WDATA) begin
        wdata_r <= sw_wdata;
      end
    end
  end

  // capture read data at end of strobe; attribute reads keep low lane only
  wire capture = (state_r == ST_PULSE) && cnt_done && !is_write;
  wire [15:0] cap_data = is_attr ? {8'h00, d_sync[7:0]} : d_sync;  // see RULE_03

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_r   <= 16'h0000;
      done_r    <= 1'b0;
      refused_r <= 1'b0;
      dout_r    <= 16'h0000;
    end else begin
      if (capture) begin
        rdata_r <= cap_data;
      end
      if (start) begin
        dout_r <= wdata_r;
      end
      // completion wins over a software clear in the same cycle
      if ((state_r == ST_GAP) && cnt_done) begin
        done_r <= 1'b1;
      end else if (start || (sw_wr && sw_addr == OFS_STATUS)) begin
        done_r <= 1'b0;
      end
      // illegal request never reaches the pins
      if (go && !new_ok) begin
        refused_r <= 1'b1;                                        // see RULE_10
      end else if (sw_wr && sw_addr == OFS_STATUS) begin
        refused_r <= 1'b0;
      end
    end
  end

  wire [15:0] status_word = {13'h0, refused_r, done_r, busy};
  wire [15:0] rd_mux = (sw_addr == OFS_CMD)    ? {8'h00, 2'h0, cmd_r.lane, 1'b0, cmd_r.op} :
                       (sw_addr == OFS_ADDR)   ? {5'h00, addr_r} :
                       (sw_addr == OFS_WDATA)  ? wdata_r :
                       (sw_addr == OFS_RDATA)  ? rdata_r :
                       (sw_addr == OFS_STATUS) ? status_word : 16'h0000;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sw_rdata_r <= 16'h0000;
    end else if (sw_rd) begin
      sw_rdata_r <= rd_mux;
    end
  end

  assign sw_rdata    = sw_rdata_r;
  assign card_pins   = pins_r;
  assign card_d_out  = dout_r;
  assign card_d_oe_n = doe_n_r;

endmodule

// ---- dv/cadec_host_properties.sv ----
`timescale 1ns/100ps
module cadec_host_properties
  import cadec_pkg::*;
(
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rstn,
  // card side
  input wire cadec_pkg::cadec_pins_t card_pins,
  input wire logic [1:0]             card_d_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire strb  = !(card_pins.oe_n && card_pins.we_n);
  wire attr  = !card_pins.reg_n && strb;
  wire idle  = card_pins.ce1_n && card_pins.ce2_n;
  attr_even_a: assert property (
    attr |-> !card_pins.addr[0] && !card_pins.ce1_n && card_pins.ce2_n)
    else $error("attribute strobe off the even byte");
  attr_lane_a: assert property (
    !card_pins.reg_n && !card_pins.we_n |-> card_d_oe_n[1])
    else $error("upper lane driven on attribute write");
  attr_dir_a: assert property (attr |-> card_pins.oe_n != card_pins.we_n)
    else $error("attribute strobes not exclusive");
  cfg_only_a: assert property (
    !card_pins.reg_n && !card_pins.we_n |-> card_pins.addr[10:3] == CFG_BASE[10:3])
    else $error("attribute write outside config registers");
  idle_float_a: assert property (idle |-> card_d_oe_n == 2'h3)
    else $error("data lanes driven while card deselected");
  delimit_a: assert property ($fell(strb) |-> !strb throughout (##[1:8] idle))
    else $error("cycle not delimited by chip enable");
  addr_hold_a: assert property (strb && $past(strb) |-> $stable(card_pins.addr))
    else $error("address moved inside a strobe");
  cover property (attr && !card_pins.oe_n);
  cover property (card_pins.reg_n && !card_pins.we_n && !card_pins.ce2_n);
  cover property (card_pins.reg_n && !card_pins.oe_n && card_pins.ce1_n);
endmodule

bind cadec_host cadec_host_properties u_props (.mclk(mclk), .rstn(rstn), .card_pins(card_pins),
  .card_d_oe_n(card_d_oe_n));

// ---- dv/cadec_card_model.sv ----
`timescale 1ns/100ps
module cadec_card_model
  import cadec_pkg::*;
(
  // clock for timing and noise
  input  wire logic                   mclk,
  input  wire logic                   slow,
  // card pins
  input  wire cadec_pkg::cadec_pins_t pins,
  input  wire logic [15:0]            d_bus,
  output logic      [15:0]            d_card
);
  logic [7:0]  cfg_r [4];
  logic [15:0] mem_r [16];
  logic [15:0] junk_r = 16'h5A3C;
  logic [4:0]  acc_r = 5'h00;
  wire         sel   = !(pins.ce1_n && pins.ce2_n);
  wire         attr  = sel && !pins.reg_n;
  wire         a_ok  = !pins.ce1_n && !pins.addr[0];
  wire         cfg   = attr && a_ok && pins.addr[10:4] == 7'h20;
  wire         rd    = sel && !pins.oe_n && pins.we_n && acc_r >= (slow ? 5'h0F : 5'h01);
  wire [3:0]   widx  = pins.addr[4:1];
  wire [7:0]   abyte = cfg ? cfg_r[pins.addr[2:1]] : pins.addr[8:1];
  wire [15:0]  rdat  = attr ? {junk_r[15:8], abyte} : mem_r[widx];
  wire         lo_on = rd && (attr ? a_ok : !pins.ce1_n);
  wire         hi_on = rd && !attr && !pins.ce2_n;
  assign d_card = {hi_on ? rdat[15:8] : junk_r[15:8], lo_on ? rdat[7:0] : junk_r[7:0]};
  // released lanes show noise, not the last value
  always_ff @(posedge mclk) begin
    junk_r <= {junk_r[14:0], ~junk_r[15]};
    acc_r  <= pins.oe_n ? 5'h00 : acc_r + 5'(acc_r != 5'h1F);
  end
  always @(posedge pins.we_n) begin
    if (cfg) begin
      cfg_r[pins.addr[2:1]] <= d_bus[7:0];
    end else if (sel && pins.reg_n) begin
      if (!pins.ce1_n) mem_r[widx][7:0] <= d_bus[7:0];
      if (!pins.ce2_n) mem_r[widx][15:8] <= d_bus[15:8];
    end
  end
endmodule

// ---- dv/cadec_host_tb.sv ----
`timescale 1ns/100ps
module cadec_host_tb;
  import cadec_pkg::*;
  logic        mclk;
  logic        rstn;
  logic        slow;
  logic [3:0]  sw_addr;
  logic [15:0] sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [15:0] sw_rdata;
  cadec_pins_t card_pins;
  logic [15:0] card_d_out;
  logic [1:0]  card_d_oe_n;
  logic [15:0] d_card;
  logic [15:0] d_bus;
  int          failures = 0;
  int          checks_done = 0;
  assign d_bus = {card_d_oe_n[1] ? d_card[15:8] : card_d_out[15:8],
                  card_d_oe_n[0] ? d_card[7:0] : card_d_out[7:0]};
  cadec_host dut (.mclk(mclk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .card_pins(card_pins),
    .card_d_in(d_bus), .card_d_out(card_d_out), .card_d_oe_n(card_d_oe_n));
  cadec_card_model card (.mclk(mclk), .slow(slow), .pins(card_pins), .d_bus(d_bus),
    .d_card(d_card));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge mclk);
    sw_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge mclk);
    sw_rd   <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic run(input logic [2:0] op, input logic [1:0] ln, input logic [10:0] a,
                     input logic [15:0] wd, output logic [15:0] s, output logic [15:0] d);
    wr(OFS_ADDR, {5'h00, a});
    wr(OFS_WDATA, wd);
    wr(OFS_CMD, {7'h00, 1'b1, 2'h0, ln, 1'b0, op});
    s = 16'h0000;
    for (int n = 0; n < ((op == CMD_STANDBY) ? 1 : 200) && s[2:1] == 2'h0; n++) begin
      rd(OFS_STATUS, s);
    end
    if (op != CMD_STANDBY) begin
      chk("cycle ended", {15'h0, |s[2:1]}, 16'h0001);
    end
    rd(OFS_RDATA, d);
    wr(OFS_STATUS, 16'h0000);
  endtask
  task automatic t_cfg;
    logic [15:0] s, d;
    for (int i = 0; i < 4; i++) begin
      run(CMD_ATTR_WR, LANE_EVEN, CFG_BASE | 11'(2 * i), {8'hFF, 8'(8'hC3 ^ i)}, s, d);
    end
    for (int i = 0; i < 4; i++) begin
      run(CMD_ATTR_RD, LANE_EVEN, CFG_BASE | 11'(2 * i), 16'h0000, s, d);
      chk("cfg status", {14'h0, s[2:1]}, 16'h0001);
      chk("cfg read", d, {8'h00, 8'(8'hC3 ^ i)});
    end
    $display("cfg test done");
  endtask
  task automatic t_mem;
    logic [15:0] s, d;
    slow <= 1'b1;
    run(CMD_MEM_WR, LANE_WORD, 11'h010, 16'h1234, s, d);
    run(CMD_MEM_WR, LANE_ODD, 11'h011, 16'hAB00, s, d);
    run(CMD_MEM_RD, LANE_WORD, 11'h010, 16'h0000, s, d);
    chk("word read", d, 16'hAB34);
    run(CMD_MEM_RD, LANE_EVEN, 11'h010, 16'h0000, s, d);
    chk("even read", {8'h00, d[7:0]}, 16'h0034);
    run(CMD_MEM_RD, LANE_ODD, 11'h011, 16'h0000, s, d);
    chk("odd read", {d[15:8], 8'h00}, 16'hAB00);
    slow <= 1'b0;
    $display("mem test done");
  endtask
  task automatic t_bad;
    logic [15:0] s, d;
    logic [2:0]  ops [6] = '{CMD_ATTR_WR, CMD_ATTR_RD, CMD_ATTR_RD, 3'h5, CMD_MEM_RD, CMD_MEM_WR};
    logic [10:0] ads [6] = '{11'h010, 11'h201, 11'h200, 11'h200, 11'h010, 11'h011};
    logic [1:0]  lns [6] = '{LANE_EVEN, LANE_EVEN, LANE_WORD, LANE_EVEN, 2'h0, LANE_WORD};
    for (int i = 0; i < 6; i++) begin
      run(ops[i], lns[i], ads[i], 16'h0055, s, d);
      chk("refused", {15'h0, s[2]}, 16'h0001);
    end
    run(CMD_ATTR_RD, LANE_EVEN, CIS_LAST, 16'h0000, s, d);
    chk("cis read", d, {8'h00, CIS_LAST[8:1]});
    run(CMD_ATTR_RD, LANE_EVEN, CFG_BASE, 16'h0000, s, d);
    chk("cfg kept", d, 16'h00C3);
    run(CMD_STANDBY, LANE_EVEN, 11'h000, 16'h0000, s, d);
    chk("standby status", s, 16'h0000);
    chk("standby pins", 16'(card_pins), 16'(PINS_IDLE));
    $display("bad access test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // 22 commands of under 100 cycles each, so 200 us is ample
  initial begin
    #200000;
    failures++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    slow = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk("reset pins", 16'(card_pins), 16'(PINS_IDLE));
    t_cfg;
    t_mem;
    t_bad;
    test_done;
  end
endmodule
